// ### verilog/rgb_backlight_control_regs.sv
// Operation
// - sequencing code 00 runs all colours overlapped, 01/10/11 run two, three or four slots.
// - brightness fades one step per pwm period only while the fade enable bit 5 is set.
// - pwm period is 1.22 kHz with fast bit 4 clear and 19.52 kHz with it set.
// - compensation is active only while bit 3 of the channel config is set.
// - bits 2, 1, 0 enable the blue, green and red sinks individually.
// - each 8-bit current code is passed linearly as 0.234 mA per count.
// - all three current code registers reset to 55h.
// - channel config resets with only the fast pwm bit set.
// - with the brightness source bit clear the external brightness pin sets brightness.
// - with the source bit set the 3-bit code gives a doubling multiplier up to full.
// - the 5-bit boost code gives the target voltage in volts from 5 to 20.
`timescale 1ns/100ps
module rgb_backlight_control_regs
	import backlight_regs_pkg::*;
#(
	parameter int SLOW_CYC = PWM_SLOW_CYC,
	parameter int FAST_CYC = PWM_FAST_CYC
) (
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wr_data,
	output      logic [7:0] rd_data,
	input  wire logic       brightness_pin,
	output      logic       red_led_sink,
	output      logic       green_led_sink,
	output      logic       blue_led_sink,
	output      logic [7:0] red_current_code,
	output      logic [7:0] green_current_code,
	output      logic [7:0] blue_current_code,
	output      logic       compensation_enable,
	output      logic [4:0] boost_voltage_code
);

	logic [7:0]         cfg_reg;
	logic [7:0]         red_reg;
	logic [7:0]         green_reg;
	logic [7:0]         blue_reg;
	logic [7:0]         bright_reg;
	logic [7:0]         boost_reg;
	logic [2:0]         level_reg;
	logic [1:0]         slot_reg;
	logic [2:0]         pin_sync_reg;
	logic               pin_level_reg;
	logic [PHASE_W-1:0] period_cyc;
	logic [PHASE_W-1:0] phase;
	logic               period_start;
	logic               pwm_on;
	logic [2:0]         slot_ok;
	logic [1:0]         order_mode;
	logic [2:0]         target;

	assign order_mode = cfg_reg[CFG_SEQ_HI:CFG_SEQ_LO];
	assign target     = bright_reg[BRI_HI:BRI_LO];

	function automatic logic [7:0] masked_write(input logic [7:0] data, input logic [7:0] mask);
		masked_write = data & mask;
	endfunction : masked_write

	function automatic logic duty_on(input logic [PHASE_W-1:0] ph,
		input logic [PHASE_W-1:0] per, input logic [2:0] lvl);
		duty_on = (lvl == LEVEL_FULL) || (ph < (per >> (3'd7 - lvl)));
	endfunction : duty_on

	// slot of a colour: red 0, green 1, blue 2 folded back to 0 in the two-slot cycle
	function automatic logic [1:0] colour_slot(input logic [1:0] colour, input logic [1:0] mode);
		if (mode == 2'h1 && colour == 2'h2) begin
			colour_slot = 2'h0;
		end else begin
			colour_slot = colour;
		end
	endfunction : colour_slot

	// register writes
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_reg <= CFG_RESET;
		end else if (wr_en && addr == ADDR_CFG) begin
			cfg_reg <= masked_write(wr_data, CFG_MASK);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			red_reg   <= CURRENT_RESET;
			green_reg <= CURRENT_RESET;
			blue_reg  <= CURRENT_RESET;
		end else if (wr_en) begin
			if (addr == ADDR_RED) begin
				red_reg <= wr_data;
			end
			if (addr == ADDR_GREEN) begin
				green_reg <= wr_data;
			end
			if (addr == ADDR_BLUE) begin
				blue_reg <= wr_data;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			bright_reg <= BRIGHT_RESET;
			boost_reg  <= BOOST_RESET;
		end else if (wr_en) begin
			if (addr == ADDR_BRIGHT) begin
				bright_reg <= masked_write(wr_data, BRIGHT_MASK);
			end
			if (addr == ADDR_BOOST) begin
				boost_reg <= masked_write(wr_data, BOOST_MASK);
			end
		end
	end

	// registered read, unmapped addresses return zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rd_data <= 8'h00;
		end else if (rd_en) begin
			unique case (addr)
				ADDR_CFG:    rd_data <= cfg_reg;
				ADDR_RED:    rd_data <= red_reg;
				ADDR_GREEN:  rd_data <= green_reg;
				ADDR_BLUE:   rd_data <= blue_reg;
				ADDR_BRIGHT: rd_data <= bright_reg & BRIGHT_MASK;
				ADDR_BOOST:  rd_data <= boost_reg & BOOST_MASK;
				default:     rd_data <= 8'h00;
			endcase
		end
	end

	// brightness pin: three stages, change taken once stages two and three agree
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_sync_reg <= 3'h0;
		end else begin
			pin_sync_reg <= {pin_sync_reg[1:0], brightness_pin};
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_level_reg <= 1'b0;
		end else if (pin_sync_reg[1] == pin_sync_reg[2]) begin
			pin_level_reg <= pin_sync_reg[2];
		end
	end

	assign period_cyc = cfg_reg[CFG_FAST] ? PHASE_W'(FAST_CYC) : PHASE_W'(SLOW_CYC);

	pwm_frame_timer #(
		.WIDTH (PHASE_W)
	) u_timer (
		.clk          (clk),
		.reset_n      (reset_n),
		.period_cyc   (period_cyc),
		.phase        (phase),
		.period_start (period_start)
	);

	// fade walks the level one code per period toward the target
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			level_reg <= 3'h0;
		end else if (!cfg_reg[CFG_FADE]) begin
			level_reg <= target;
		end else if (period_start) begin
			if (level_reg < target) begin
				level_reg <= level_reg + 3'h1;
			end else if (level_reg > target) begin
				level_reg <= level_reg - 3'h1;
			end
		end
	end

	// sequential slot counter wraps after order_mode+1 periods
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			slot_reg <= 2'h0;
		end else if (order_mode == SEQ_OVERLAP) begin
			slot_reg <= 2'h0;
		end else if (period_start) begin
			slot_reg <= (slot_reg >= order_mode) ? 2'h0 : slot_reg + 2'h1;
		end
	end

	always_comb begin
		if (order_mode == SEQ_OVERLAP) begin
			slot_ok = 3'h7;
		end else begin
			slot_ok[0] = (slot_reg == colour_slot(2'h0, order_mode));
			slot_ok[1] = (slot_reg == colour_slot(2'h1, order_mode));
			slot_ok[2] = (slot_reg == colour_slot(2'h2, order_mode));
		end
	end

	assign pwm_on = bright_reg[BRI_SRC] ? duty_on(phase, period_cyc, level_reg)
		: pin_level_reg;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			red_led_sink   <= 1'b0;
			green_led_sink <= 1'b0;
			blue_led_sink  <= 1'b0;
		end else begin
			red_led_sink   <= cfg_reg[CFG_EN_R] & slot_ok[0] & pwm_on;
			green_led_sink <= cfg_reg[CFG_EN_G] & slot_ok[1] & pwm_on;
			blue_led_sink  <= cfg_reg[CFG_EN_B] & slot_ok[2] & pwm_on;
		end
	end

	// current codes pass straight to the linear sink dacs
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			red_current_code    <= CURRENT_RESET;
			green_current_code  <= CURRENT_RESET;
			blue_current_code   <= CURRENT_RESET;
			compensation_enable <= 1'b0;
			boost_voltage_code  <= 5'h00;
		end else begin
			red_current_code    <= red_reg;
			green_current_code  <= green_reg;
			blue_current_code   <= blue_reg;
			compensation_enable <= cfg_reg[CFG_AUTO];
			boost_voltage_code  <= boost_reg[BOOST_HI:0];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// fade and level
	fade_hold_a: assert property (!cfg_reg[CFG_FADE] |=> level_reg == $past(target))
		else $error("level not following target with fade off");
	fade_step_a: assert property (cfg_reg[CFG_FADE] && period_start && level_reg < target
		|=> level_reg == $past(level_reg) + 3'h1)
		else $error("fade did not step up");
	fade_down_a: assert property (cfg_reg[CFG_FADE] && period_start && level_reg > target
		|=> level_reg == $past(level_reg) - 3'h1)
		else $error("fade did not step down");
	fade_wait_a: assert property (cfg_reg[CFG_FADE] && !period_start
		|=> level_reg == $past(level_reg))
		else $error("fade stepped between periods");

	// pwm period
	pwm_period_a: assert property (period_start |=> phase == '0)
		else $error("period not ending at period count");
	period_len_a: assert property (period_start && $stable(period_cyc)
		|-> phase == period_cyc - PHASE_W'(1))
		else $error("period length wrong");

	// outputs and enables
	comp_follow_a: assert property (##1 compensation_enable == $past(cfg_reg[CFG_AUTO]))
		else $error("compensation output wrong");
	enable_gate_a: assert property (!cfg_reg[CFG_EN_R] |=> !red_led_sink)
		else $error("red sink on while disabled");
	green_gate_a: assert property (!cfg_reg[CFG_EN_G] |=> !green_led_sink)
		else $error("green sink on while disabled");
	blue_gate_a: assert property (!cfg_reg[CFG_EN_B] |=> !blue_led_sink)
		else $error("blue sink on while disabled");
	current_write_a: assert property (wr_en && addr == ADDR_RED
		|=> ##1 red_current_code == $past(wr_data, 2))
		else $error("red current code not updated");
	green_write_a: assert property (wr_en && addr == ADDR_GREEN
		|=> ##1 green_current_code == $past(wr_data, 2))
		else $error("green current code not updated");
	blue_write_a: assert property (wr_en && addr == ADDR_BLUE
		|=> ##1 blue_current_code == $past(wr_data, 2))
		else $error("blue current code not updated");

	// sequencing
	slot_wrap_a: assert property (period_start && order_mode != SEQ_OVERLAP
		&& slot_reg == order_mode |=> slot_reg == 2'h0)
		else $error("sequence slot did not wrap");
	slot_overlap_a: assert property (order_mode == SEQ_OVERLAP |=> slot_reg == 2'h0)
		else $error("slot moving in overlap mode");
	seq_apart_a: assert property (order_mode != SEQ_OVERLAP
		|=> !(red_led_sink && green_led_sink))
		else $error("red and green share a slot");
	dark_slot_a: assert property (order_mode == 2'h3 && slot_reg == 2'h3
		|=> !red_led_sink && !green_led_sink && !blue_led_sink)
		else $error("fourth slot not dark");
	blue_pair_a: assert property (order_mode == 2'h1 && cfg_reg[CFG_EN_B]
		&& cfg_reg[CFG_EN_R] |=> blue_led_sink == red_led_sink)
		else $error("blue not sharing the red slot");

	// brightness source and boost code
	standalone_a: assert property (!bright_reg[BRI_SRC] && cfg_reg[CFG_EN_R]
		&& order_mode == SEQ_OVERLAP |=> red_led_sink == $past(pin_level_reg))
		else $error("stand-alone sink not following pin");
	pin_hold_a: assert property (pin_sync_reg[1] != pin_sync_reg[2]
		|=> pin_level_reg == $past(pin_level_reg))
		else $error("pin level taken before stages agree");
	bright_full_a: assert property (bright_reg[BRI_SRC] && level_reg == LEVEL_FULL
		&& cfg_reg[CFG_EN_R] && order_mode == SEQ_OVERLAP |=> red_led_sink)
		else $error("full brightness not continuous");
	boost_write_a: assert property (wr_en && addr == ADDR_BOOST
		|=> ##1 boost_voltage_code == $past(wr_data[4:0], 2))
		else $error("boost code not updated");

	// read side
	reserved_zero_a: assert property (rd_en && addr == ADDR_BRIGHT
		|=> rd_data[7:5] == 3'h0 && !rd_data[3])
		else $error("reserved bits read nonzero");
	boost_zero_a: assert property (rd_en && addr == ADDR_BOOST
		|=> rd_data[7:5] == 3'h0)
		else $error("boost reserved bits read nonzero");
	unmapped_zero_a: assert property (rd_en && addr > ADDR_BOOST |=> rd_data == 8'h00)
		else $error("unmapped read nonzero");

	fade_cov_c: cover property (cfg_reg[CFG_FADE] && period_start && level_reg != target);
	seq_four_c: cover property (order_mode == 2'h3 && slot_reg == 2'h3 && period_start);
	seq_three_c: cover property (order_mode == 2'h2 && slot_reg == 2'h2 && period_start);
	standalone_c: cover property (!bright_reg[BRI_SRC] && $rose(red_led_sink));
	fast_pwm_c: cover property (cfg_reg[CFG_FAST] && period_start);

endmodule : rgb_backlight_control_regs

// ### verilog/backlight_regs_pkg.sv
package backlight_regs_pkg;

	localparam logic [7:0] ADDR_CFG    = 8'h00;
	localparam logic [7:0] ADDR_RED    = 8'h01;
	localparam logic [7:0] ADDR_GREEN  = 8'h02;
	localparam logic [7:0] ADDR_BLUE   = 8'h03;
	localparam logic [7:0] ADDR_BRIGHT = 8'h04;
	localparam logic [7:0] ADDR_BOOST  = 8'h05;

	// led_channel_config fields
	localparam int CFG_SEQ_HI = 7;
	localparam int CFG_SEQ_LO = 6;
	localparam int CFG_FADE   = 5;
	localparam int CFG_FAST   = 4;
	localparam int CFG_AUTO   = 3;
	localparam int CFG_EN_B   = 2;
	localparam int CFG_EN_G   = 1;
	localparam int CFG_EN_R   = 0;

	// brightness_select and boost fields
	localparam int BRI_SRC    = 4;
	localparam int BRI_HI     = 2;
	localparam int BRI_LO     = 0;
	localparam int BOOST_HI   = 4;

	localparam logic [7:0] CFG_RESET     = 8'h10;
	localparam logic [7:0] CURRENT_RESET = 8'h55;
	localparam logic [7:0] BRIGHT_RESET  = 8'h00;
	localparam logic [7:0] BOOST_RESET   = 8'h00;
	localparam logic [7:0] CFG_MASK      = 8'hff;
	localparam logic [7:0] BRIGHT_MASK   = 8'h17;
	localparam logic [7:0] BOOST_MASK    = 8'h1f;

	localparam logic [1:0] SEQ_OVERLAP = 2'h0;
	localparam logic [2:0] LEVEL_FULL  = 3'h7;

	// pwm timing
	localparam int CLK_PERIOD_PS      = 4000;
	localparam int PWM_SLOW_PERIOD_PS = 819672131;
	localparam int PWM_FAST_PERIOD_PS = 51229508;
	localparam int PWM_SLOW_CYC       = PWM_SLOW_PERIOD_PS / CLK_PERIOD_PS;
	localparam int PWM_FAST_CYC       = PWM_FAST_PERIOD_PS / CLK_PERIOD_PS;
	localparam int PHASE_W            = 18;

endpackage : backlight_regs_pkg

// ### verilog/pwm_frame_timer.sv
`timescale 1ns/100ps
module pwm_frame_timer
	import backlight_regs_pkg::*;
#(
	parameter int WIDTH = PHASE_W
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] period_cyc,
	output      logic [WIDTH-1:0] phase,
	output      logic             period_start
);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase <= '0;
		end else if (period_start || phase >= period_cyc - WIDTH'(1)) begin
			phase <= '0;
		end else begin
			phase <= phase + WIDTH'(1);
		end
	end

	// one-cycle pulse on the last cycle of each period
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			period_start <= 1'b0;
		end else begin
			period_start <= (phase == period_cyc - WIDTH'(2));
		end
	end

endmodule : pwm_frame_timer

// ### test/host_model.sv
`timescale 1ns/100ps
module host_model (
	input  wire logic       clk,
	output      logic       wr_en,
	output      logic       rd_en,
	output      logic [7:0] addr,
	output      logic [7:0] wr_data,
	input  wire logic [7:0] rd_data
);
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wr_data = 8'h00;
	end
	// one-cycle strobe; released lines scrambled
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'b0;
		addr <= ~a;
		wr_data <= ~d;
	endtask : write
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_en <= 1'b0;
		addr <= ~a;
		#1;
		d = rd_data;
	endtask : read
endmodule : host_model

// ### test/testbench.sv
`timescale 1ns/100ps
module testbench;
	import backlight_regs_pkg::*;
	logic       clk, reset_n, wr_en, rd_en, pin, rs, gs, bs, comp;
	logic [7:0] addr, wr_data, rd_data, rc, gc, bc, v;
	logic [4:0] boost;
	int         failures, total_checks, r, g, b, rg;

	host_model host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wr_data(wr_data), .rd_data(rd_data));
	rgb_backlight_control_regs #(.SLOW_CYC(64), .FAST_CYC(16)) dut_u (
		.clk(clk), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wr_data(wr_data), .rd_data(rd_data), .brightness_pin(pin),
		.red_led_sink(rs), .green_led_sink(gs), .blue_led_sink(bs),
		.red_current_code(rc), .green_current_code(gc), .blue_current_code(bc),
		.compensation_enable(comp), .boost_voltage_code(boost));

	task automatic wrap_up;
		if (failures == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_cnt(input int got, input int exp);
		total_checks++;
		if (got != exp) begin
			failures++;
			$display("[ERR] %0t count %0d expected %0d", $time, got, exp);
		end
	endtask : chk_cnt
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		host_u.read(a, v);
		chk(v, exp);
	endtask : rd_chk
	task automatic count(input int n);
		r = 0; g = 0; b = 0; rg = 0;
		repeat (n) begin
			@(negedge clk);
			r += (rs === 1'b1);
			g += (gs === 1'b1);
			b += (bs === 1'b1);
			rg += (rs === 1'b1 && gs === 1'b1);
		end
	endtask : count
	// bounded wait for the red sink to reach a level
	task automatic wait_red(input logic lvl);
		int i;
		for (i = 0; i < 10 && rs !== lvl; i++)
			@(negedge clk);
		chk({7'h0, rs}, {7'h0, lvl});
		if (rs !== lvl)
			wrap_up();
	endtask : wait_red

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		reset_n = 1'b0;
		pin = 1'b0;
		failures = 0;
		total_checks = 0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		rd_chk(ADDR_CFG, 8'h10);
		for (int i = 1; i < 4; i++) rd_chk(i[7:0], 8'h55);
		chk(rc & gc & bc, 8'h55);
		rd_chk(ADDR_BRIGHT, 8'h00);
		host_u.write(ADDR_BRIGHT, 8'hff);
		rd_chk(ADDR_BRIGHT, 8'h17);
		host_u.write(ADDR_BOOST, 8'hf4);
		rd_chk(ADDR_BOOST, 8'h14);
		host_u.write(8'h06, 8'hff);
		rd_chk(8'h06, 8'h00);
		for (int c = 5; c <= 20; c += 15) begin
			host_u.write(ADDR_BOOST, c[7:0]);
			repeat (2) @(negedge clk);
			chk({3'h0, boost}, c[7:0]);
		end
		for (int c = 0; c < 256; c += 255) begin
			for (int i = 1; i < 4; i++) host_u.write(i[7:0], c[7:0]);
			repeat (2) @(negedge clk);
			chk(rc & gc & bc, c[7:0]);
			chk(rc | gc | bc, c[7:0]);
		end
		host_u.write(ADDR_CFG, 8'h18);
		repeat (2) @(negedge clk);
		chk({7'h0, comp}, 8'h01);
		// stand-alone: pin gates the sinks
		host_u.write(ADDR_BRIGHT, 8'h07);
		host_u.write(ADDR_CFG, 8'h17);
		@(posedge clk) pin <= 1'b1;
		wait_red(1'b1);
		chk({6'h0, gs, bs}, 8'h03);
		chk({7'h0, comp}, 8'h00);
		@(posedge clk) pin <= 1'b0;
		wait_red(1'b0);
		host_u.write(ADDR_CFG, 8'h16);
		@(posedge clk) pin <= 1'b1;
		repeat (10) @(negedge clk);
		chk({5'h0, rs, gs, bs}, 8'h03);
		@(posedge clk) pin <= 1'b0;
		// register brightness: level 1 separates slow from fast
		host_u.write(ADDR_BRIGHT, 8'h11);
		host_u.write(ADDR_CFG, 8'h07);
		repeat (128) @(negedge clk);
		count(128);
		chk_cnt(r, 2);
		host_u.write(ADDR_CFG, 8'h17);
		repeat (64) @(negedge clk);
		count(128);
		chk_cnt(r, 0);
		host_u.write(ADDR_BRIGHT, 8'h17);
		for (int m = 0; m < 4; m++) begin
			host_u.write(ADDR_CFG, {m[1:0], 6'h17});
			repeat (64) @(negedge clk);
			count(192);
			chk_cnt(r, 192 / (m + 1));
			chk_cnt(g + b, 384 / (m + 1));
			chk_cnt(rg, (m == 0) ? 192 : 0);
		end
		host_u.write(ADDR_CFG, 8'h37);
		host_u.write(ADDR_BRIGHT, 8'h10);
		repeat (4) @(negedge clk);
		count(16);
		chk_cnt(r > 0, 1);
		repeat (200) @(negedge clk);
		count(32);
		chk_cnt(r, 0);
		host_u.write(ADDR_BRIGHT, 8'h17);
		host_u.write(ADDR_CFG, 8'h17);
		host_u.write(ADDR_BRIGHT, 8'h10);
		repeat (20) @(negedge clk);
		count(32);
		chk_cnt(r, 0);
		// mid-run reset brings back the defaults
		@(posedge clk) reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rd_chk(ADDR_CFG, 8'h10);
		rd_chk(ADDR_RED, 8'h55);
		chk(rc & gc & bc, 8'h55);
		wrap_up();
	end
endmodule : testbench
